// file: src/pel_consts.svh
// Register map, field positions, mode codes and reset values of the edge accumulator
`ifndef PEL_CONSTS_SVH
`define PEL_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PEL_OFS_CTRL 8'h00
`define PEL_OFS_INC 8'h04
`define PEL_OFS_ACC 8'h08
`define PEL_OFS_STAT 8'h0C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PEL_MODE_HI 30
`define PEL_MODE_LO 26
`define PEL_BSEL_HI 13
`define PEL_BSEL_LO 9
`define PEL_ASEL_HI 4
`define PEL_ASEL_LO 0

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define PEL_MODE_OFF 5'h00
`define PEL_MODE_NEVER 5'h10
`define PEL_MODE_ALWAYS 5'h1F
`define PEL_MODE_POS 5'h08
`define PEL_MODE_POS_FB 5'h09
`define PEL_MODE_RISE 5'h0A
`define PEL_MODE_NEG 5'h0C
`define PEL_MODE_NEG_FB 5'h0D
`define PEL_MODE_FALL 5'h0E
`define PEL_MODE_XOR 5'h16
`define PEL_MODE_XNOR 5'h19
`define PEL_MODE_LA 5'h1A
`define PEL_MODE_NLA 5'h15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PEL_RST_WORD 32'h0000_0000

`endif

// file: src/pel_pkg.sv
// Types shared by the edge accumulator modules
package pel_pkg;

	typedef logic [4:0] pel_mode_t;
	typedef logic [4:0] pel_sel_t;

	typedef struct packed {
		pel_mode_t mode;
		pel_sel_t bsel;
		pel_sel_t asel;
	} pel_ctrl_s;

	typedef struct packed {
		logic a;
		logic a_dly;
		logic b;
	} pel_smp_s;

endpackage : pel_pkg

// file: src/pel_cond.sv
// Accumulate condition and feedback decode for one counter
`timescale 1ns/10ps
`default_nettype none
`include "pel_consts.svh"

module pel_cond (
	// Clock and reset, for checks only
	input wire logic ref_clk,
	input wire logic resetn,
	// Mode and pin samples
	input wire pel_pkg::pel_mode_t mode,
	input wire pel_pkg::pel_smp_s smp,
	// Decoded outputs
	output logic acc_en,
	output logic fb_en
);

	logic lvl;
	logic lvl_dly;

	// Polarity bit selects high/rising versus low/falling
	assign lvl = smp.a ^ mode[2];
	assign lvl_dly = smp.a_dly ^ mode[2];

	always_comb begin
		acc_en = 1'b0;
		fb_en = 1'b0;
		if (mode[4]) begin
			// Low nibble is a truth table indexed by {B, A}
			acc_en = mode[{smp.b, smp.a}];
		end else if (mode[3]) begin
			if (mode[1])
				acc_en = lvl & ~lvl_dly;
			else
				acc_en = lvl;
			fb_en = mode[0];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	xor_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode == `PEL_MODE_XOR |-> acc_en == (smp.a != smp.b))
		else $error("xor mode accumulate mismatch");

	xnor_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode == `PEL_MODE_XNOR |-> acc_en == (smp.a == smp.b))
		else $error("xnor mode accumulate mismatch");

	alias_modes_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(mode == `PEL_MODE_POS || mode == `PEL_MODE_LA) |-> acc_en == smp.a)
		else $error("positive level alias mismatch");

	fall_edge_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode == `PEL_MODE_FALL |-> acc_en == (!smp.a && smp.a_dly))
		else $error("falling edge detect mismatch");

endmodule : pel_cond

`default_nettype wire

// file: src/pel_top.sv
// APB-mapped pin logic and edge accumulator, one counter
`timescale 1ns/10ps
`default_nettype none
`include "pel_consts.svh"

module pel_top #(
	parameter int NPINS = 32
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic [NPINS-1:0] pin_i,
	output logic [NPINS-1:0] pin_o,
	output logic [NPINS-1:0] pin_oe
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	pel_pkg::pel_ctrl_s ctrl_ff;
	logic [31:0] inc_ff;
	logic [31:0] acc_ff;
	logic [NPINS-1:0] sync1_ff;
	logic [NPINS-1:0] sync2_ff;
	pel_pkg::pel_smp_s smp_ff;
	logic [NPINS-1:0] pin_o_ff;
	logic [NPINS-1:0] pin_oe_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic acc_en;
	logic fb_en;
	logic wr_acc;
	logic wr_ctrl;
	logic wr_inc;
	logic access;
	logic [31:0] nxt_rdata;
	logic nxt_err;

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
		addr_hit = (a == ofs);
	endfunction : addr_hit

	function automatic pel_pkg::pel_ctrl_s ctrl_unpack(input logic [31:0] w);
		pel_pkg::pel_ctrl_s c;
		c.mode = w[`PEL_MODE_HI:`PEL_MODE_LO];
		c.bsel = w[`PEL_BSEL_HI:`PEL_BSEL_LO];
		c.asel = w[`PEL_ASEL_HI:`PEL_ASEL_LO];
		ctrl_unpack = c;
	endfunction : ctrl_unpack

	function automatic logic [31:0] ctrl_pack(input pel_pkg::pel_ctrl_s c);
		logic [31:0] w;
		w = `PEL_RST_WORD;
		w[`PEL_MODE_HI:`PEL_MODE_LO] = c.mode;
		w[`PEL_BSEL_HI:`PEL_BSEL_LO] = c.bsel;
		w[`PEL_ASEL_HI:`PEL_ASEL_LO] = c.asel;
		ctrl_pack = w;
	endfunction : ctrl_pack

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// No wait state: pready rises in the first access cycle
	assign access = psel & penable & pready_ff;
	assign wr_ctrl = access & pwrite & addr_hit(paddr, `PEL_OFS_CTRL);
	assign wr_inc = access & pwrite & addr_hit(paddr, `PEL_OFS_INC);
	assign wr_acc = access & pwrite & addr_hit(paddr, `PEL_OFS_ACC);

	always_comb begin
		nxt_rdata = `PEL_RST_WORD;
		nxt_err = 1'b0;
		case (paddr)
			`PEL_OFS_CTRL: nxt_rdata = ctrl_pack(ctrl_ff);
			`PEL_OFS_INC: nxt_rdata = inc_ff;
			`PEL_OFS_ACC: nxt_rdata = acc_ff;
			`PEL_OFS_STAT: nxt_rdata = {29'h0000_0000, smp_ff.b, smp_ff.a_dly, smp_ff.a};
			default: nxt_err = 1'b1;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= `PEL_RST_WORD;
		end else begin
			pready_ff <= psel & ~penable;
			pslverr_ff <= psel & ~penable & nxt_err;
			// Accumulator read is a snapshot from the setup cycle
			if (psel & ~penable)
				prdata_ff <= pwrite ? `PEL_RST_WORD : nxt_rdata;
		end
	end

	// ----------------------------------------
	// Control and increment registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn)
			ctrl_ff <= '0;
		else if (wr_ctrl)
			ctrl_ff <= ctrl_unpack(pwdata);
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn)
			inc_ff <= `PEL_RST_WORD;
		else if (wr_inc)
			inc_ff <= pwdata;
	end

	// ----------------------------------------
	// Pin synchroniser and samples
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= pin_i;
			sync2_ff <= sync1_ff;
		end
	end

	// Buffered sample feeds the equation of the next cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn)
			smp_ff <= '0;
		else begin
			smp_ff.a <= sync2_ff[ctrl_ff.asel];
			smp_ff.a_dly <= smp_ff.a;
			smp_ff.b <= sync2_ff[ctrl_ff.bsel];
		end
	end

	pel_cond u_cond (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.mode(ctrl_ff.mode),
		.smp(smp_ff),
		.acc_en(acc_en),
		.fb_en(fb_en)
	);

	// ----------------------------------------
	// Phase accumulator
	// ----------------------------------------
	// Software write wins over an accumulate in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn)
			acc_ff <= `PEL_RST_WORD;
		else if (wr_acc)
			acc_ff <= pwdata;
		else if (acc_en)
			acc_ff <= 32'(acc_ff + inc_ff);
	end

	// ----------------------------------------
	// Feedback drive
	// ----------------------------------------
	// Only the selected second pin is ever driven; logic modes leave it input
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pin_o_ff <= '0;
			pin_oe_ff <= '0;
		end else begin
			pin_o_ff <= '0;
			pin_oe_ff <= '0;
			if (fb_en) begin
				pin_o_ff[ctrl_ff.bsel] <= ~smp_ff.a;
				pin_oe_ff[ctrl_ff.bsel] <= 1'b1;
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign pin_o = pin_o_ff;
	assign pin_oe = pin_oe_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence no_acc_write;
		!wr_acc;
	endsequence

	sequence mode_write_always;
		wr_ctrl && pwdata[`PEL_MODE_HI:`PEL_MODE_LO] == `PEL_MODE_ALWAYS && !wr_inc;
	endsequence

	never_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		((ctrl_ff.mode == `PEL_MODE_NEVER || ctrl_ff.mode == `PEL_MODE_OFF) and no_acc_write) |=> $stable(acc_ff))
		else $error("accumulator moved in never mode");

	always_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		((ctrl_ff.mode == `PEL_MODE_ALWAYS) and no_acc_write) |=> acc_ff == 32'($past(acc_ff) + $past(inc_ff)))
		else $error("always mode missed an add");

	sample_delay_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		$stable(ctrl_ff) |=> smp_ff.a == $past(sync2_ff[ctrl_ff.asel]) && smp_ff.a_dly == $past(smp_ff.a))
		else $error("pin sample is not one cycle old");

	mode_start_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode_write_always ##1 no_acc_write |=> acc_ff == 32'($past(acc_ff) + inc_ff))
		else $error("new mode did not start at once");

	rise_edge_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		((ctrl_ff.mode == `PEL_MODE_RISE && smp_ff.a && !smp_ff.a_dly) and no_acc_write)
		|=> acc_ff == 32'($past(acc_ff) + $past(inc_ff)))
		else $error("rising edge not counted");

	feedback_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(ctrl_ff.mode == `PEL_MODE_POS_FB || ctrl_ff.mode == `PEL_MODE_NEG_FB) && $stable(ctrl_ff)
		|=> pin_oe_ff[ctrl_ff.bsel] && pin_o_ff[ctrl_ff.bsel] == !$past(smp_ff.a))
		else $error("feedback pin not driven inverted");

	logic_no_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		ctrl_ff.mode[4] && $stable(ctrl_ff) |=> pin_oe_ff == '0)
		else $error("logic mode drove a pin");

	neg_alias_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(((ctrl_ff.mode == `PEL_MODE_NEG || ctrl_ff.mode == `PEL_MODE_NLA) && !smp_ff.a) and no_acc_write)
		|=> acc_ff == 32'($past(acc_ff) + $past(inc_ff)))
		else $error("low level alias not counted");

	wrap_add_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		((acc_en && ({1'b0, acc_ff} + {1'b0, inc_ff}) >= 33'h1_0000_0000) and no_acc_write)
		|=> acc_ff < $past(acc_ff))
		else $error("accumulator did not wrap");

	apb_answer_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		psel && !penable |=> pready_ff)
		else $error("apb answer late");

	sequence rise_seen;
		!smp_ff.a ##1 smp_ff.a && ctrl_ff.mode == `PEL_MODE_RISE && !wr_acc;
	endsequence

	sequence fall_seen;
		smp_ff.a ##1 !smp_ff.a && ctrl_ff.mode == `PEL_MODE_FALL && !wr_acc;
	endsequence

	rise_count_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		rise_seen |=> acc_ff == 32'($past(acc_ff) + $past(inc_ff)))
		else $error("rising edge from sample history not counted");

	fall_count_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		fall_seen |=> acc_ff == 32'($past(acc_ff) + $past(inc_ff)))
		else $error("falling edge from sample history not counted");

	edge_only_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		((ctrl_ff.mode == `PEL_MODE_RISE && !(smp_ff.a && !smp_ff.a_dly)) and no_acc_write) |=> $stable(acc_ff))
		else $error("rise mode added without an edge");

	pos_feedback_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		((ctrl_ff.mode == `PEL_MODE_POS_FB && smp_ff.a) and no_acc_write)
		|=> acc_ff == 32'($past(acc_ff) + $past(inc_ff)))
		else $error("high level with feedback not counted");

	acc_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		((!acc_en) and no_acc_write) |=> $stable(acc_ff))
		else $error("accumulator moved without a condition");

	acc_add_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		((acc_en) and no_acc_write) |=> acc_ff == 32'($past(acc_ff) + $past(inc_ff)))
		else $error("accumulate did not add the increment");

	unimpl_idle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		((ctrl_ff.mode[4:3] == 2'b00) and no_acc_write) |=> $stable(acc_ff) && pin_oe_ff == '0)
		else $error("unimplemented mode was active");

	acc_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_acc |=> acc_ff == $past(pwdata))
		else $error("accumulator write lost");

	inc_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_inc |=> inc_ff == $past(pwdata))
		else $error("increment write lost");

	mode_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_ctrl |=> ctrl_ff.mode == $past(pwdata[`PEL_MODE_HI:`PEL_MODE_LO]))
		else $error("mode write lost");

	fb_single_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		fb_en |=> $onehot(pin_oe_ff))
		else $error("feedback drove other than one pin");

	pready_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		pready_ff |=> !pready_ff)
		else $error("apb answer longer than one cycle");

	slverr_map_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		psel && !penable && paddr > `PEL_OFS_STAT |=> pslverr_ff)
		else $error("unmapped address not flagged");

	write_rdata_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		psel && !penable && pwrite |=> prdata_ff == `PEL_RST_WORD)
		else $error("read data not zero for a write");

endmodule : pel_top

`default_nettype wire

// file: tb/pel_pins_model.sv
// Pin-side model: external levels, floating lines and the feedback wire
`timescale 1ns/10ps
`default_nettype none
module pel_pins_model (
	// Clock
	input wire logic ref_clk,
	// Levels and selects
	input wire logic a_lvl,
	input wire logic b_lvl,
	input wire logic [4:0] asel,
	input wire logic [4:0] bsel,
	// Design pins
	input wire logic [31:0] pin_o,
	input wire logic [31:0] pin_oe,
	output logic [31:0] pin_i
);
	logic [31:0] idle_ff = 32'h5555_5555;
	// Floating lines toggle so a stale level never looks valid
	always_ff @(posedge ref_clk) begin
		idle_ff <= ~idle_ff;
	end
	always_comb begin
		pin_i = idle_ff;
		pin_i[asel] = a_lvl;
		pin_i[bsel] = b_lvl;
		for (int i = 0; i < 32; i++) begin
			if (pin_oe[i] === 1'b1) begin
				pin_i[i] = pin_o[i];
			end
		end
	end
endmodule : pel_pins_model
`default_nettype wire

// file: tb/tb_pin_logic_edge_accumulator.sv
// Self-checking bench for the pin logic edge accumulator
`timescale 1ns/10ps
`default_nettype none
`include "pel_consts.svh"
module tb_pin_logic_edge_accumulator;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] pin_i;
	logic [31:0] pin_o;
	logic [31:0] pin_oe;
	logic a_lvl = 1'b0;
	logic b_lvl = 1'b0;
	logic [31:0] rd;
	logic err;
	int n_mismatch = 0;
	int checks = 0;
	localparam logic [4:0] ASEL = 5'h05;
	localparam logic [4:0] BSEL = 5'h11;

	pel_top #(.NPINS(32)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
	pel_pins_model i_pins (.ref_clk(ref_clk), .a_lvl(a_lvl), .b_lvl(b_lvl), .asel(ASEL), .bsel(BSEL),
		.pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

	initial begin
		forever begin
			#12.5 ref_clk = ~ref_clk;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; starts one edge after the call so strobes never toggle twice in a step
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Answer taken at the rising edge that sees pready; only the watchdog ends a hang
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [31:0] ctrl(input logic [4:0] m);
		logic [31:0] w;
		w = 32'h0;
		w[`PEL_MODE_HI:`PEL_MODE_LO] = m;
		w[`PEL_BSEL_HI:`PEL_BSEL_LO] = BSEL;
		w[`PEL_ASEL_HI:`PEL_ASEL_LO] = ASEL;
		return w;
	endfunction : ctrl

	// Expected accumulate condition of every mode for static pin levels
	function automatic logic exp_acc(input logic [4:0] m, input logic a, input logic b);
		case (m)
			5'h11: return !a && !b;
			5'h12: return a && !b;
			5'h13: return !b;
			5'h14: return !a && b;
			5'h15: return !a;
			5'h16: return a != b;
			5'h17: return !a || !b;
			5'h18: return a && b;
			5'h19: return a == b;
			5'h1A: return a;
			5'h1B: return a || !b;
			5'h1C: return b;
			5'h1D: return !a || b;
			5'h1E: return a || b;
			5'h1F: return 1'b1;
			5'h08, 5'h09: return a;
			5'h0C, 5'h0D: return !a;
			default: return 1'b0;
		endcase
	endfunction : exp_acc

	task automatic t_reset();
		apb(1'b0, `PEL_OFS_CTRL, 32'h0);
		chk(rd, `PEL_RST_WORD);
		apb(1'b0, `PEL_OFS_INC, 32'h0);
		chk(rd, `PEL_RST_WORD);
		apb(1'b0, `PEL_OFS_ACC, 32'h0);
		chk(rd, `PEL_RST_WORD);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test reset done");
	endtask : t_reset

	// Every mode against every static pin pair; four adds fit between the two mode writes
	task automatic t_modes();
		logic [4:0] m;
		logic c;
		logic fb;
		apb(1'b1, `PEL_OFS_INC, 32'h0000_0003);
		for (int i = 0; i < 128; i++) begin
			m = i[6:2];
			@(posedge ref_clk);
			a_lvl <= i[0];
			b_lvl <= i[1];
			apb(1'b1, `PEL_OFS_ACC, 32'h0);
			apb(1'b1, `PEL_OFS_CTRL, ctrl(m));
			repeat (2) @(negedge ref_clk);
			fb = (m[4:3] == 2'b01) && m[0];
			chk(pin_oe, fb ? 32'h1 << BSEL : 32'h0);
			if (fb) begin
				chk({31'h0, pin_o[BSEL]}, {31'h0, ~i[0]});
			end
			apb(1'b1, `PEL_OFS_CTRL, ctrl(`PEL_MODE_OFF));
			apb(1'b0, `PEL_OFS_ACC, 32'h0);
			c = exp_acc(m, i[0], i[1]);
			chk(rd, c ? 32'h0000_000C : 32'h0);
		end
		$display("test modes done");
	endtask : t_modes

	task automatic t_edges();
		logic [4:0] em [4] = '{`PEL_MODE_RISE, 5'h0B, `PEL_MODE_FALL, 5'h0F};
		apb(1'b1, `PEL_OFS_INC, 32'h0000_0001);
		foreach (em[k]) begin
			@(posedge ref_clk);
			a_lvl <= 1'b0;
			apb(1'b1, `PEL_OFS_ACC, 32'h0);
			apb(1'b1, `PEL_OFS_CTRL, ctrl(em[k]));
			repeat (3) begin
				@(posedge ref_clk);
				a_lvl <= 1'b1;
				repeat (4) @(posedge ref_clk);
				a_lvl <= 1'b0;
				repeat (4) @(posedge ref_clk);
			end
			apb(1'b1, `PEL_OFS_CTRL, ctrl(`PEL_MODE_OFF));
			apb(1'b0, `PEL_OFS_ACC, 32'h0);
			chk(rd, 32'h0000_0003);
		end
		$display("test edges done");
	endtask : t_edges

	task automatic t_wrap();
		apb(1'b1, `PEL_OFS_INC, 32'h0000_0010);
		apb(1'b1, `PEL_OFS_ACC, 32'hFFFF_FFF0);
		apb(1'b1, `PEL_OFS_CTRL, ctrl(`PEL_MODE_ALWAYS));
		apb(1'b1, `PEL_OFS_CTRL, ctrl(`PEL_MODE_OFF));
		apb(1'b0, `PEL_OFS_ACC, 32'h0);
		chk(rd, 32'h0000_0020);
		apb(1'b0, `PEL_OFS_STAT, 32'h0);
		chk(rd, {29'h0, b_lvl, a_lvl, a_lvl});
		$display("test wrap done");
	endtask : t_wrap

	task automatic end_of_test();
		$display("Counts: checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_modes();
		t_edges();
		t_wrap();
		end_of_test();
	end

	// Tests need about 2000 cycles
	initial begin
		#(25 * 20000);
		n_mismatch++;
		end_of_test();
	end
endmodule : tb_pin_logic_edge_accumulator
`default_nettype wire
